// ---- hw/ctw_can_xcvr.sv ----
// Purpose: mode, wake-up and bus fault logic of a high-speed CAN transceiver
// Assumes: all pin inputs synchronous to i_clk except bus fault comparators
// Notes:   control bits arrive as plain ports, write strobes are one cycle
//
// Overview of operation
// - transmit/receive mode: driver and receiver on, bus follows txd, rxd shows bus
// - receive-only mode: driver off, receiver on, txd ignored
// - driver armed only in transmit/receive mode with txd high
// - txd high releases bus recessive, txd low drives both lines dominant
// - rxd high for recessive comparator, low for dominant
// - three slew settings, fastest after reset
// - txd dominant timeout no shorter than 300 us
// - sleep: drivers off, terminations to ground, split output off
// - bus wake sets readable flag, event pulse and device wake
// - leaving sleep restores recessive bias on both lines
// - bus wake only when wake enable is set
// - default wake: three pulses over 500 ns within 120 us
// - single-pulse select: wake on one 2 us dominant pulse
// - ground comparators decode ground shorts and which line
// - battery comparators decode battery shorts and which line
// - five-volt comparators decode 5 V shorts and which line
// - recessive samples detect a fault, dominant samples pick the line
// - fault reported only after five equal consecutive decodes
// - driver stays off until failure gone, flags read, mode reselected
`timescale 1ns/1ps
module ctw_can_xcvr #(
  parameter int TXD_DOM_CYC  = ctw_pkg::TXD_DOM_CYC,
  parameter int SETTLE_CYC   = ctw_pkg::SETTLE_CYC,
  parameter int FAULT_CYCLES = ctw_pkg::FAULT_CYCLES
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic       i_mode_wr,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_slew_wr,
  input  wire logic [1:0] i_slew,
  input  wire logic       i_wake_en,
  input  wire logic       i_single_pulse_wake_select,
  input  wire logic       i_flags_rd,
  input  wire logic       i_txd,
  input  wire logic       i_bus_dom,
  input  wire logic       i_wake_bus_dom,
  input  wire logic       i_low_line_ground_cmp,
  input  wire logic       i_high_line_ground_cmp,
  input  wire logic       i_low_line_battery_cmp,
  input  wire logic       i_high_line_battery_cmp,
  input  wire logic       i_low_line_five_volt_cmp,
  input  wire logic       i_high_line_five_volt_cmp,
  output logic            o_rxd,
  output logic            o_rx_en,
  output logic            o_drv_en,
  output logic            o_drv_dom,
  output logic            o_term_gnd,
  output logic            o_split_en,
  output logic            o_wake_rx_en,
  output logic [1:0]      o_slew,
  output logic            o_wake_flag,
  output logic            o_wake_pulse,
  output logic            o_dev_wake,
  output logic            o_txd_dom_flag,
  output logic            o_fault_valid,
  output logic [2:0]      o_fault_code
);
  if (TXD_DOM_CYC < 2 || TXD_DOM_CYC > 65535 || SETTLE_CYC < 1 || SETTLE_CYC > 255
      || FAULT_CYCLES < 2 || FAULT_CYCLES > 7) begin : g_bad_param
    $error("ctw_can_xcvr: unsupported timing parameters");
  end

  localparam int CW = ctw_pkg::CMP_W;

  // recessive samples find the fault, dominant samples name the line
  function automatic ctw_pkg::ctw_fault_t decode(input logic [CW-1:0] rec,
                                                 input logic [CW-1:0] dom);
    ctw_pkg::ctw_fault_t f;
    f = ctw_pkg::FLT_NONE;
    if (!rec[ctw_pkg::CMP_LG] && !rec[ctw_pkg::CMP_HG]) begin
      if (!dom[ctw_pkg::CMP_LG] && !dom[ctw_pkg::CMP_HG])
        f = ctw_pkg::FLT_GND_H;
      else if (!dom[ctw_pkg::CMP_LG] && dom[ctw_pkg::CMP_HG])
        f = ctw_pkg::FLT_GND_L;
    end else if (rec[ctw_pkg::CMP_LB] && rec[ctw_pkg::CMP_HB]) begin
      // battery first: a battery short also trips the 5 V comparators
      if (dom[ctw_pkg::CMP_LB] && dom[ctw_pkg::CMP_HB])
        f = ctw_pkg::FLT_BAT_L;
      else if (!dom[ctw_pkg::CMP_LB] && dom[ctw_pkg::CMP_HB])
        f = ctw_pkg::FLT_BAT_H;
    end else if (rec[ctw_pkg::CMP_L5] && rec[ctw_pkg::CMP_H5]) begin
      if (dom[ctw_pkg::CMP_L5] && dom[ctw_pkg::CMP_H5])
        f = ctw_pkg::FLT_V5_L;
      else if (!dom[ctw_pkg::CMP_L5] && dom[ctw_pkg::CMP_H5])
        f = ctw_pkg::FLT_V5_H;
    end
    return f;
  endfunction

  logic [1:0]          mode_r;
  logic [1:0]          slew_r;
  logic                drv_en_r;
  logic                drv_dom_r;
  logic                rxd_r;
  logic [15:0]         dom_cnt_r;
  logic                fail_r;
  logic                blk_r;
  logic                wake_flag_r;
  logic                wake_pulse_r;
  logic                dev_wake_r;
  logic [CW-1:0]       cmp_s1_r;
  logic [CW-1:0]       cmp_s2_r;
  logic [CW-1:0]       rec_r;
  logic                have_rec_r;
  logic [7:0]          settle_r;
  logic [2:0]          q_cnt_r;
  ctw_pkg::ctw_fault_t last_r;
  ctw_pkg::ctw_fault_t fault_r;
  logic                fault_valid_r;
  logic                wake_ev;

  wire [CW-1:0] cmp_in = {i_high_line_five_volt_cmp, i_low_line_five_volt_cmp,
                          i_high_line_battery_cmp, i_low_line_battery_cmp,
                          i_high_line_ground_cmp, i_low_line_ground_cmp};

  // mode selection; unused code 3 leaves the mode unchanged
  wire       mode_ok  = i_mode_wr & (i_mode != 2'h3);
  wire [1:0] mode_nxt = mode_ok ? i_mode : mode_r;
  wire       is_sleep = (mode_r == ctw_pkg::MODE_SLEEP);
  wire       is_txrx  = (mode_r == ctw_pkg::MODE_TXRX);
  wire       slew_ok  = i_slew_wr & (i_slew != 2'h3);

  // txd stuck dominant while driving
  wire dom_run  = drv_en_r & ~i_txd;
  wire fail_set = dom_run & (dom_cnt_r == 16'(TXD_DOM_CYC - 1));
  wire fail_clr = i_flags_rd & i_txd;
  wire unblk    = ~fail_r & mode_ok & (i_mode == ctw_pkg::MODE_TXRX);
  wire blk_nxt  = fail_set | (blk_r & ~unblk);
  wire drv_en_nxt = (mode_nxt == ctw_pkg::MODE_TXRX) & ~blk_nxt & (drv_en_r | i_txd);

  // fault sampling, phase follows the registered driver state
  wire settled   = (settle_r == 8'(SETTLE_CYC - 1));
  wire take_rec  = drv_en_r & settled & ~drv_dom_r;
  wire take_dom  = drv_en_r & settled & drv_dom_r & have_rec_r;
  ctw_pkg::ctw_fault_t dec;
  assign dec = decode(rec_r, cmp_s2_r);
  wire same_flt  = (dec == last_r);
  wire qual_hit  = take_dom & (dec != ctw_pkg::FLT_NONE) & same_flt
                   & (q_cnt_r == 3'(FAULT_CYCLES - 1));

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_r   <= ctw_pkg::MODE_RST;
      slew_r   <= ctw_pkg::SLEW_FAST;
      drv_en_r <= 1'b0;
      drv_dom_r <= 1'b0;
      rxd_r    <= 1'b1;
      blk_r    <= 1'b0;
    end else begin
      mode_r   <= mode_nxt;
      if (slew_ok)
        slew_r <= i_slew;
      drv_en_r <= drv_en_nxt;
      drv_dom_r <= drv_en_nxt & ~i_txd;
      rxd_r    <= is_sleep ? 1'b1 : ~i_bus_dom;
      blk_r    <= blk_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      dom_cnt_r <= 16'h0000;
      fail_r    <= 1'b0;
    end else begin
      // counter saturates so a held fault does not wrap
      if (!dom_run)
        dom_cnt_r <= 16'h0000;
      else if (!fail_set)
        dom_cnt_r <= dom_cnt_r + 16'h0001;
      // a new failure wins over a read in the same cycle
      fail_r <= fail_set | (fail_r & ~fail_clr);
    end
  end

  ctw_wake_det u_wake (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_en     (is_sleep & i_wake_en),
    .i_single (i_single_pulse_wake_select),
    .i_dom    (i_wake_bus_dom),
    .o_wake   (wake_ev)
  );

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wake_flag_r  <= 1'b0;
      wake_pulse_r <= 1'b0;
      dev_wake_r   <= 1'b0;
    end else begin
      wake_pulse_r <= wake_ev;
      wake_flag_r  <= wake_ev | (wake_flag_r & ~i_flags_rd);
      // wake request holds until the next mode write, ignored code 3 included
      dev_wake_r   <= wake_ev | (dev_wake_r & ~i_mode_wr);
    end
  end

  // two-stage sync: comparators are analog and asynchronous
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cmp_s1_r <= '0;
      cmp_s2_r <= '0;
    end else begin
      cmp_s1_r <= cmp_in;
      cmp_s2_r <= cmp_s1_r;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || !drv_en_r) begin
      settle_r   <= 8'h00;
      have_rec_r <= 1'b0;
      rec_r      <= '0;
    end else begin
      // restart the settle count on every driver transition
      if (drv_dom_r != (drv_en_nxt & ~i_txd))
        settle_r <= 8'h00;
      else if (!settled)
        settle_r <= settle_r + 8'h01;
      if (take_rec && !have_rec_r) begin
        rec_r      <= cmp_s2_r;
        have_rec_r <= 1'b1;
      end else if (take_dom) begin
        have_rec_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      q_cnt_r       <= 3'h0;
      last_r        <= ctw_pkg::FLT_NONE;
      fault_r       <= ctw_pkg::FLT_NONE;
      fault_valid_r <= 1'b0;
    end else if (take_dom) begin
      last_r <= dec;
      if (dec == ctw_pkg::FLT_NONE) begin
        q_cnt_r       <= 3'h0;
        fault_valid_r <= 1'b0;
        fault_r       <= ctw_pkg::FLT_NONE;
      end else if (!same_flt) begin
        q_cnt_r       <= 3'h1;
        fault_valid_r <= 1'b0;
        fault_r       <= ctw_pkg::FLT_NONE;
      end else if (qual_hit) begin
        fault_valid_r <= 1'b1;
        fault_r       <= dec;
      end else if (q_cnt_r < 3'(FAULT_CYCLES - 1)) begin
        q_cnt_r <= q_cnt_r + 3'h1;
      end
    end
  end

  assign o_rxd          = rxd_r;
  assign o_drv_en       = drv_en_r;
  assign o_drv_dom      = drv_dom_r;
  assign o_rx_en        = ~is_sleep;
  assign o_term_gnd     = is_sleep;
  assign o_split_en     = ~is_sleep;
  assign o_wake_rx_en   = is_sleep & i_wake_en;
  assign o_slew         = slew_r;
  assign o_wake_flag    = wake_flag_r;
  assign o_wake_pulse   = wake_pulse_r;
  assign o_dev_wake     = dev_wake_r;
  assign o_txd_dom_flag = fail_r;
  assign o_fault_valid  = fault_valid_r;
  assign o_fault_code   = fault_r;

  chk_rxonly_nodrv: assert property (@(posedge i_clk) disable iff (i_rst)
    !is_txrx |-> !o_drv_en && !o_drv_dom)
    else $error("driver active outside transmit/receive mode");

  chk_rxd_follow: assert property (@(posedge i_clk) disable iff (i_rst)
    !is_sleep |=> (o_rxd == !$past(i_bus_dom)))
    else $error("rxd does not follow the bus comparator");

  chk_arm_on_high: assert property (@(posedge i_clk) disable iff (i_rst)
    !o_drv_en ##1 o_drv_en |-> $past(i_txd) && is_txrx)
    else $error("driver armed while txd low");

  chk_dom_drive: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_txd |=> (o_drv_dom == o_drv_en))
    else $error("txd low did not drive dominant");

  chk_rec_release: assert property (@(posedge i_clk) disable iff (i_rst)
    i_txd |=> !o_drv_dom)
    else $error("txd high did not release the bus");

  chk_txd_timeout: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_txd_dom_flag) |-> $past(dom_cnt_r) == 16'(TXD_DOM_CYC - 1))
    else $error("txd dominant flagged too early");

  chk_sleep_state: assert property (@(posedge i_clk) disable iff (i_rst)
    is_sleep |-> o_term_gnd && !o_split_en && !o_drv_en && !o_drv_dom)
    else $error("sleep outputs wrong");

  chk_wake_gate: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_wake_en [*3] |-> !o_wake_pulse)
    else $error("wake pulse while wake disabled");

  chk_wake_flag: assert property (@(posedge i_clk) disable iff (i_rst)
    o_wake_pulse |-> o_wake_flag && o_dev_wake)
    else $error("wake pulse without flag");

  chk_fault_qual: assert property (@(posedge i_clk) disable iff (i_rst)
    $rose(o_fault_valid) |-> $past(q_cnt_r) == 3'(FAULT_CYCLES - 1) && $past(take_dom))
    else $error("fault reported before five cycles");

  chk_slew_reset: assert property (@(posedge i_clk)
    $past(i_rst) && !i_rst |-> o_slew == ctw_pkg::SLEW_FAST)
    else $error("slew not fastest after reset");

  chk_block_hold: assert property (@(posedge i_clk) disable iff (i_rst)
    blk_r |-> !o_drv_en)
    else $error("driver enabled while blocked");

  chk_leave_sleep: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(is_sleep) |-> !o_term_gnd && o_split_en && !o_drv_dom)
    else $error("bias not restored after sleep");

  chk_fault_code_set: assert property (@(posedge i_clk) disable iff (i_rst)
    o_fault_valid |-> o_fault_code != ctw_pkg::FLT_NONE)
    else $error("fault reported without a code");

  chk_fault_on_dom: assert property (@(posedge i_clk) disable iff (i_rst)
    $changed(o_fault_code) |-> $past(take_dom))
    else $error("fault code changed outside a dominant sample");

  chk_wake_set_wins: assert property (@(posedge i_clk) disable iff (i_rst)
    wake_ev |=> o_wake_flag && o_wake_pulse)
    else $error("wake event lost against a flag read");

  chk_fail_set_wins: assert property (@(posedge i_clk) disable iff (i_rst)
    fail_set |=> o_txd_dom_flag && !o_drv_en)
    else $error("txd timeout lost against a flag read");

  chk_wake_off: assert property (@(posedge i_clk) disable iff (i_rst)
    !(is_sleep && i_wake_en) |=> !wake_ev)
    else $error("wake event while detection disabled");
endmodule

// ---- hw/ctw_pkg.sv ----
// Purpose: shared constants and types for the CAN transceiver control block
// Assumes: 20 MHz clock
// Notes:   time figures kept in their own unit, cycle counts derived
package ctw_pkg;

  localparam int CLK_NS = 50;

  // least time: round up
  localparam int TXD_DOM_US  = 300;
  localparam int TXD_DOM_CYC = (TXD_DOM_US * 1000 + CLK_NS - 1) / CLK_NS;

  // a valid wake pulse must exceed this
  localparam int WAKE_PULSE_NS  = 500;
  localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS + CLK_NS - 1) / CLK_NS;

  // longest time: round down
  localparam int WAKE_WIN_US  = 120;
  localparam int WAKE_WIN_CYC = (WAKE_WIN_US * 1000) / CLK_NS;

  localparam int WAKE_SINGLE_NS  = 2000;
  localparam int WAKE_SINGLE_CYC = (WAKE_SINGLE_NS + CLK_NS - 1) / CLK_NS;

  localparam int WAKE_PULSES  = 3;
  localparam int FAULT_CYCLES = 5;

  // driver settle time before comparators are sampled
  localparam int SETTLE_NS  = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [1:0] MODE_SLEEP  = 2'h0;
  localparam logic [1:0] MODE_RXONLY = 2'h1;
  localparam logic [1:0] MODE_TXRX   = 2'h2;
  localparam logic [1:0] MODE_RST    = MODE_RXONLY;

  localparam logic [1:0] SLEW_FAST = 2'h0;
  localparam logic [1:0] SLEW_MED  = 2'h1;
  localparam logic [1:0] SLEW_SLOW = 2'h2;

  // comparator vector bit positions
  localparam int CMP_LG = 0;
  localparam int CMP_HG = 1;
  localparam int CMP_LB = 2;
  localparam int CMP_HB = 3;
  localparam int CMP_L5 = 4;
  localparam int CMP_H5 = 5;
  localparam int CMP_W  = 6;

  typedef enum logic [2:0] {
    FLT_NONE,
    FLT_GND_L,
    FLT_GND_H,
    FLT_BAT_L,
    FLT_BAT_H,
    FLT_V5_L,
    FLT_V5_H
  } ctw_fault_t;

endpackage

// ---- hw/ctw_wake_det.sv ----
// Purpose: bus wake-up pattern detector, single or triple dominant pulse
// Assumes: i_dom synchronous to i_clk; detector cleared while i_en is low
// Notes:   o_wake is a one-cycle registered pulse
`timescale 1ns/1ps
module ctw_wake_det #(
  parameter int PULSE_CYC  = ctw_pkg::WAKE_PULSE_CYC,
  parameter int WIN_CYC    = ctw_pkg::WAKE_WIN_CYC,
  parameter int SINGLE_CYC = ctw_pkg::WAKE_SINGLE_CYC,
  parameter int PULSES     = ctw_pkg::WAKE_PULSES
) (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_en,
  input  wire logic i_single,
  input  wire logic i_dom,
  output logic      o_wake
);
  if (PULSE_CYC < 1 || SINGLE_CYC <= PULSE_CYC || SINGLE_CYC > 65535 || WIN_CYC >= 65535
      || PULSES < 1 || PULSES > 7) begin : g_bad_param
    $error("ctw_wake_det: unsupported timing parameters");
  end

  logic [15:0] plen_r;
  logic [15:0] win_r;
  logic [2:0]  cnt_r;
  logic        dom_d_r;
  logic        wake_r;

  wire pulse_end   = dom_d_r & ~i_dom;
  wire pulse_ok    = pulse_end & (plen_r > 16'(PULSE_CYC));
  wire single_hit  = i_single & i_dom & (plen_r == 16'(SINGLE_CYC - 1));
  wire win_over    = (cnt_r != 3'h0) & (win_r == 16'(WIN_CYC - 1));
  wire pattern_hit = ~i_single & pulse_ok & ~win_over & (cnt_r == 3'(PULSES - 1));

  always_ff @(posedge i_clk) begin
    if (i_rst || !i_en) begin
      plen_r  <= 16'h0000;
      win_r   <= 16'h0000;
      cnt_r   <= 3'h0;
      dom_d_r <= 1'b0;
      wake_r  <= 1'b0;
    end else begin
      dom_d_r <= i_dom;
      wake_r  <= single_hit | pattern_hit;
      if (!i_dom)
        plen_r <= 16'h0000;
      else if (plen_r != 16'hffff)
        plen_r <= plen_r + 16'h0001;
      // window runs from the first valid pulse; expiry restarts the pattern
      if (win_over || pattern_hit || i_single) begin
        cnt_r <= 3'h0;
        win_r <= 16'h0000;
      end else begin
        if (pulse_ok)
          cnt_r <= cnt_r + 3'h1;
        if (cnt_r != 3'h0)
          win_r <= win_r + 16'h0001;
      end
    end
  end

  assign o_wake = wake_r;
endmodule

// ---- tb/ctw_can_xcvr_test.sv ----
// Purpose: self-checking bench for the transceiver mode, wake and fault logic
// Assumes: short timeout and settle parameters, comparators modelled from drv_dom
// Notes:   phases are long enough for sync plus settle before each sample
`timescale 1ns/1ps
module ctw_can_xcvr_test;
  localparam int TDOM = 20;
  localparam int SETTLE = 6;
  localparam int PH = 14;
  logic clk = 1'b0, rst = 1'b1, mode_wr = 1'b0, slew_wr = 1'b0, wake_en = 1'b0;
  logic single = 1'b0, flags_rd = 1'b0, tx_bit = 1'b1, bus_dom = 1'b0, wbus = 1'b0;
  logic [1:0] mode = 2'h0, slew = 2'h0, slew_o, exp_s, v;
  logic [2:0] flt = 3'h0, flt_code;
  logic [5:0] cmp = 6'h03;
  logic rxd, rx_en, drv_en, drv_dom, term_gnd, split_en, wake_rx_en, wake_flag;
  logic wake_pulse, dev_wake, txd_flag, flt_valid, txd, t, b;
  int n_fail = 0, checks = 0, n_wake = 0, k;
  int   w_len [8] = '{50, 30, 50, 10, 12, 12, 12, 12};
  int   w_n   [8] = '{1, 1, 1, 3, 2, 3, 3, 3};
  int   w_gap [8] = '{12, 12, 12, 12, 12, 12, 1300, 1100};
  logic w_en  [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
  logic w_sgl [8] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  int   w_exp [8] = '{0, 0, 1, 0, 0, 1, 0, 1};

  always #25 clk = ~clk;

  ctw_mcu_model mcu_u (.i_clk(clk), .i_rst(rst), .i_bit(tx_bit), .i_rxd(rxd),
                       .o_txd(txd), .o_rx_seen());

  ctw_can_xcvr #(.TXD_DOM_CYC(TDOM), .SETTLE_CYC(SETTLE), .FAULT_CYCLES(5)) dut_u (
    .i_clk(clk), .i_rst(rst), .i_mode_wr(mode_wr), .i_mode(mode), .i_slew_wr(slew_wr),
    .i_slew(slew), .i_wake_en(wake_en), .i_single_pulse_wake_select(single),
    .i_flags_rd(flags_rd), .i_txd(txd), .i_bus_dom(bus_dom), .i_wake_bus_dom(wbus),
    .i_low_line_ground_cmp(cmp[0]), .i_high_line_ground_cmp(cmp[1]),
    .i_low_line_battery_cmp(cmp[2]), .i_high_line_battery_cmp(cmp[3]),
    .i_low_line_five_volt_cmp(cmp[4]), .i_high_line_five_volt_cmp(cmp[5]),
    .o_rxd(rxd), .o_rx_en(rx_en), .o_drv_en(drv_en), .o_drv_dom(drv_dom),
    .o_term_gnd(term_gnd), .o_split_en(split_en), .o_wake_rx_en(wake_rx_en),
    .o_slew(slew_o), .o_wake_flag(wake_flag), .o_wake_pulse(wake_pulse),
    .o_dev_wake(dev_wake), .o_txd_dom_flag(txd_flag), .o_fault_valid(flt_valid),
    .o_fault_code(flt_code));

  // comparator levels per injected short and driver phase, {h5,l5,hb,lb,hg,lg}
  function automatic logic [5:0] cmp_of(input logic [2:0] f, input logic d);
    logic [5:0] c;
    c = d ? 6'h02 : 6'h03;
    case (f)
      3'h1: c[1:0] = d ? 2'h2 : 2'h0;
      3'h2: c[1:0] = 2'h0;
      3'h3: c[3:2] = 2'h3;
      3'h4: c[3:2] = d ? 2'h2 : 2'h3;
      3'h5: c[5:4] = 2'h3;
      3'h6: c[5:4] = d ? 2'h2 : 2'h3;
      default: ;
    endcase
    return c;
  endfunction

  always @(posedge clk) begin
    cmp <= cmp_of(flt, drv_dom);
    if (wake_pulse === 1'b1) n_wake++;
  end

  task automatic give_verdict();
    if (n_fail == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // sel low writes the mode, high the slew code; one-cycle strobe
  task automatic wr(input logic sel, input logic [1:0] val);
    @(posedge clk);
    if (sel) begin
      slew_wr <= 1'b1;
      slew    <= val;
    end else begin
      mode_wr <= 1'b1;
      mode    <= val;
    end
    @(posedge clk);
    slew_wr <= 1'b0;
    mode_wr <= 1'b0;
    #1;
  endtask

  task automatic pulse_rd();
    @(posedge clk);
    flags_rd <= 1'b1;
    @(posedge clk);
    flags_rd <= 1'b0;
    #1;
  endtask

  task automatic run_cycles(input int n, input logic [2:0] f);
    @(posedge clk);
    flt <= f;
    repeat (n) begin
      tx_bit <= 1'b1;
      repeat (PH) @(posedge clk);
      tx_bit <= 1'b0;
      repeat (PH) @(posedge clk);
    end
    #1;
  endtask

  // wake enable dropped first so each case starts with a cleared detector
  task automatic pulses(input logic en, input logic sgl, input int len, input int n,
                        input int gap);
    @(posedge clk);
    wake_en <= 1'b0;
    @(posedge clk);
    wake_en <= en;
    single  <= sgl;
    repeat (3) @(posedge clk);
    repeat (n) begin
      wbus <= 1'b1;
      repeat (len) @(posedge clk);
      wbus <= 1'b0;
      repeat (gap) @(posedge clk);
    end
    #1;
  endtask

  initial begin
    #2_000_000;
    n_fail++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h6e62));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk(rx_en === 1'b1 && drv_en === 1'b0 && rxd === 1'b1, "reset mode state");
    chk(slew_o === ctw_pkg::SLEW_FAST, "slew after reset");
    exp_s = ctw_pkg::SLEW_FAST;
    for (int i = 0; i < 8; i++) begin
      v = (i == 3) ? 2'h3 : 2'($urandom_range(3));
      wr(1'b1, v);
      tick(1);
      if (v != 2'h3) exp_s = v;
      chk(slew_o === exp_s, "slew select");
    end
    for (int i = 0; i < 30; i++) begin
      @(posedge clk);
      b = bus_dom;
      bus_dom <= 1'($urandom_range(1));
      tx_bit  <= 1'($urandom_range(1));
      #1;
      chk(rxd === ~b && drv_en === 1'b0 && drv_dom === 1'b0, "receive only");
    end
    @(posedge clk);
    tx_bit <= 1'b0;
    tick(3);
    wr(1'b0, ctw_pkg::MODE_TXRX);
    tick(3);
    chk(drv_en === 1'b0 && drv_dom === 1'b0, "driver armed with txd low");
    @(posedge clk);
    tx_bit <= 1'b1;
    tick(3);
    chk(drv_en === 1'b1 && rx_en === 1'b1, "driver armed");
    for (int i = 0; i < 40; i++) begin
      @(posedge clk);
      t = txd;
      b = bus_dom;
      tx_bit  <= (i % 4 == 3) ? 1'b1 : 1'($urandom_range(1));
      bus_dom <= 1'($urandom_range(1));
      #1;
      chk(drv_en === 1'b1 && drv_dom === ~t && rxd === ~b, "link");
    end
    @(posedge clk);
    tx_bit <= 1'b0;
    do @(posedge clk); while (txd !== 1'b0);
    for (int i = 1; i < TDOM; i++) begin
      #1;
      chk(txd_flag === 1'b0 && drv_dom === 1'b1, "early dominant flag");
      @(posedge clk);
    end
    #1;
    chk(txd_flag === 1'b1 && drv_en === 1'b0 && drv_dom === 1'b0, "dominant timeout");
    @(posedge clk);
    tx_bit <= 1'b1;
    tick(3);
    chk(drv_en === 1'b0, "driver blocked before read");
    pulse_rd();
    tick(1);
    chk(txd_flag === 1'b0 && drv_en === 1'b0, "driver blocked until mode write");
    wr(1'b0, ctw_pkg::MODE_TXRX);
    tick(2);
    chk(drv_en === 1'b1, "driver re-enabled");
    for (int f = 1; f <= 6; f++) begin
      run_cycles(2, 3'h0);
      chk(flt_valid === 1'b0, "fault report cleared");
      run_cycles(4, 3'(f));
      chk(flt_valid === 1'b0, "fault reported early");
      run_cycles(2, 3'(f));
      chk(flt_valid === 1'b1 && flt_code === 3'(f), "fault code");
    end
    run_cycles(2, 3'h0);
    @(posedge clk);
    tx_bit <= 1'b1;
    wr(1'b0, ctw_pkg::MODE_SLEEP);
    tick(2);
    chk(term_gnd === 1'b1 && split_en === 1'b0 && drv_en === 1'b0 && rx_en === 1'b0, "sleep");
    for (int i = 0; i < 8; i++) begin
      k = n_wake;
      pulses(w_en[i], w_sgl[i], w_len[i], w_n[i], w_gap[i]);
      chk(wake_rx_en === w_en[i] && drv_dom === 1'b0, "wake receiver");
      chk(n_wake - k == w_exp[i], "wake events");
      if (w_exp[i] == 1) begin
        chk(wake_flag === 1'b1 && dev_wake === 1'b1, "wake flag");
        pulse_rd();
        tick(1);
        chk(wake_flag === 1'b0, "wake flag clear");
      end
    end
    wr(1'b0, ctw_pkg::MODE_TXRX);
    tick(2);
    chk(dev_wake === 1'b0 && term_gnd === 1'b0 && split_en === 1'b1, "leave sleep");
    chk(drv_en === 1'b1 && drv_dom === 1'b0, "recessive after sleep");
    wr(1'b0, 2'h3);
    tick(2);
    chk(drv_en === 1'b1 && rx_en === 1'b1, "mode code 3 ignored");
    wr(1'b0, ctw_pkg::MODE_RXONLY);
    tick(2);
    chk(drv_en === 1'b0 && drv_dom === 1'b0 && rx_en === 1'b1, "receive-only write");
    give_verdict();
  end
endmodule

// ---- tb/ctw_mcu_model.sv ----
// Purpose: controller side of the txd/rxd link, one bit handed in per clock
// Assumes: bit requests come from the bench at the rising edge
// Notes:   txd held recessive through reset so the driver cannot fire early
`timescale 1ns/1ps
module ctw_mcu_model (
  input  wire logic i_clk,
  input  wire logic i_rst,
  input  wire logic i_bit,
  input  wire logic i_rxd,
  output logic      o_txd,
  output logic      o_rx_seen
);
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_txd     <= 1'b1;
      o_rx_seen <= 1'b1;
    end else begin
      // high is recessive, low dominant
      o_txd     <= i_bit;
      o_rx_seen <= i_rxd;
    end
  end
endmodule
